// ===== logic/ptsq_device.sv
// Port transfer engine: program store, sequencer and transfer path
// Behaviour
// (RULE_01) Program store holds up to 256 bytes
// (RULE_02) Exactly one of load, execute, halt; reset load
// (RULE_03) Execute port read in load starts execution
// (RULE_04) Halt instruction parks engine until load command
// (RULE_05) Load port read always forces load mode
// (RULE_06) Load mode reacts to program write, execute read
// (RULE_07) Stored program reruns via load then execute
// (RULE_08) Load port write stores next program byte
// (RULE_09) Four 8-bit registers: port, data, pc, loop
// (RULE_10) Port register drives address during transfers
// (RULE_11) Data register source drives system data bus
// (RULE_12) Jump loads program counter with operand
// (RULE_13) Software loads loop counter with complemented count
// (RULE_14) One instruction decrements, tests, jumps non-zero
// (RULE_15) One destination and one source per transfer
// (RULE_16) Data register to GPIB needs non-existent port
// (RULE_17) Phantom port answers nothing, safe dummy target
// (RULE_18) Sustain GPIB transfers up to 200K bytes/s
// (RULE_19) Switch port bit 5 shows program running
// (RULE_20) Load entry clears pc, write flag advances it
// (RULE_21) Bus taken by request, released by acknowledge
// (RULE_22) Opcodes 01 halt, 83..87 with operand byte
// (RULE_23) Execute fetches bytes from zero, pc advances
`timescale 1ns/1ps
module ptsq_device #(
	parameter int DEPTH = ptsq_pkg::PTSQ_PROG_DEPTH
) (
	input  wire logic             ref_clk_i,
	input  wire logic             sys_rst_i,
	ptsq_if.dev                   link,
	output ptsq_pkg::ptsq_mode_t  mode_o
);
	import ptsq_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// The program counter is eight bits wide, so the store cannot grow
	initial begin
		if (DEPTH < 2 || DEPTH > PTSQ_PROG_DEPTH || (1 << AW) != DEPTH)
		begin
			$error("ptsq_device: DEPTH must be a power of two up to 256");
		end
	end

	typedef enum logic [2:0] {
		ST_LOAD,
		ST_FETCH,
		ST_ARG,
		ST_HALT,
		ST_XREQ,
		ST_XSRC,
		ST_XWAIT,
		ST_XDST
	} ptsq_state_t;

	// Opcode classification, bits 6:5 are don't-care
	function automatic ptsq_kind_t decode(input logic [7:0] op);
		logic [7:0] m;
		m = op & PTSQ_OP_MASK;
		if (m == PTSQ_OP_HALT)
			decode = PTSQ_K_HALT;
		else if (m == PTSQ_OP_JUMP)
			decode = PTSQ_K_JUMP;
		else if (m == PTSQ_OP_LDATA)
			decode = PTSQ_K_LDATA;
		else if (m == PTSQ_OP_LPORT)
			decode = PTSQ_K_LPORT;
		else if (m == PTSQ_OP_LLOOP)
			decode = PTSQ_K_LLOOP;
		else if (m == PTSQ_OP_LOOP)
			decode = PTSQ_K_LOOP;
		else if (op[7] && !op[2] && op[4:3] != PTSQ_DST_NONE
			&& op[1:0] != PTSQ_SRC_NONE
			&& !(op[4:3] == PTSQ_DST_GPIB && op[1:0] == PTSQ_SRC_GPIB))
			decode = PTSQ_K_XFER;
		else
			decode = PTSQ_K_NOP;
	endfunction

	logic [7:0]  mem [DEPTH];
	ptsq_state_t st_q,    st_d;
	logic [7:0]  pc_q,    pc_d;
	logic [7:0]  op_q,    op_d;
	logic [7:0]  port_q,  port_d;
	logic [7:0]  dreg_q,  dreg_d;
	logic [7:0]  loop_q,  loop_d;
	logic [7:0]  xfer_q,  xfer_d;
	logic        flag_q,  flag_d;
	logic        mem_we;
	logic [7:0]  mem_rd;
	logic [7:0]  loop_inc;
	logic        rd_exec;
	logic        rd_load;
	logic        wr_load;
	logic        dst_gpib;
	logic [1:0]  src;

	// Host command decode off the I/O strobes
	assign rd_exec  = link.io_rd && link.io_addr == PTSQ_PORT_EXEC;
	assign rd_load  = link.io_rd && link.io_addr == PTSQ_PORT_LOAD;
	assign wr_load  = link.io_wr && link.io_addr == PTSQ_PORT_LOAD;
	assign mem_rd   = mem[pc_q[AW-1:0]];
	assign loop_inc = loop_q + 8'h01;
	assign dst_gpib = op_q[4:3] == PTSQ_DST_GPIB;
	assign src      = op_q[1:0];

	// Sequencer next state
	always_comb begin
		st_d           = st_q;
		pc_d           = pc_q;
		op_d           = op_q;
		port_d         = port_q;
		dreg_d         = dreg_q;
		loop_d         = loop_q;
		xfer_d         = xfer_q;
		flag_d         = 1'b0;
		mem_we         = 1'b0;
		link.sys_rd    = 1'b0;
		link.sys_wr    = 1'b0;
		link.gpib_rd   = 1'b0;
		link.gpib_wr   = 1'b0;
		if (rd_load)
		begin
			// Also the abort path: works in any mode, pc restarts at zero
			st_d = ST_LOAD; // RULE_05 RULE_07
			pc_d = '0; // RULE_20
		end
		else
		begin
			case (st_q)
				ST_LOAD:
				begin
					if (flag_q)
						pc_d = pc_q + 8'h01; // RULE_20
					if (wr_load)
					begin
						mem_we = 1'b1; // RULE_06 RULE_08
						flag_d = 1'b1; // RULE_20
					end
					else if (rd_exec)
					begin
						st_d = ST_FETCH; // RULE_03 RULE_06
						pc_d = '0; // RULE_23
					end
				end
				ST_FETCH:
				begin
					op_d = mem_rd;
					pc_d = pc_q + 8'h01; // RULE_23
					case (decode(mem_rd))
						PTSQ_K_HALT:
						begin
							pc_d = '0; // RULE_22
							st_d = ST_HALT; // RULE_04
						end
						PTSQ_K_XFER: st_d = ST_XREQ;
						PTSQ_K_NOP:  st_d = ST_FETCH;
						default:     st_d = ST_ARG; // RULE_22
					endcase
				end
				ST_ARG:
				begin
					pc_d = pc_q + 8'h01; // RULE_23
					st_d = ST_FETCH;
					case (decode(op_q))
						PTSQ_K_JUMP:  pc_d = mem_rd; // RULE_12
						PTSQ_K_LDATA: dreg_d = mem_rd; // RULE_09
						PTSQ_K_LPORT: port_d = mem_rd; // RULE_09
						PTSQ_K_LLOOP: loop_d = mem_rd; // RULE_09 RULE_13
						PTSQ_K_LOOP:
						begin
							// Counting up an inverted count is counting down
							loop_d = loop_inc; // RULE_14
							if (loop_inc != PTSQ_LOOP_DONE)
								pc_d = mem_rd; // RULE_14
						end
						default: st_d = ST_FETCH;
					endcase
				end
				ST_HALT:
				begin
					// Execute reads are ignored here on purpose
					st_d = ST_HALT; // RULE_04
				end
				ST_XREQ:
				begin
					xfer_d = dreg_q; // RULE_11
					if (link.bus_ack && (!(dst_gpib || src == PTSQ_SRC_GPIB)
						|| link.gpib_rdy))
						st_d = ST_XSRC; // RULE_21
				end
				ST_XSRC:
				begin
					if (src == PTSQ_SRC_GPIB)
					begin
						link.gpib_rd = 1'b1; // RULE_15
						xfer_d       = link.gpib_rdata;
						st_d         = ST_XDST;
					end
					else if (src == PTSQ_SRC_PORT || dst_gpib)
					begin
						// Data register stays on the bus; a live port wins
						link.sys_rd = 1'b1; // RULE_15 RULE_16
						st_d        = ST_XWAIT;
					end
					else
						st_d = ST_XDST; // RULE_11
				end
				ST_XWAIT:
				begin
					if (link.sys_rvalid)
					begin
						xfer_d = link.sys_rdata; // RULE_16
						st_d   = ST_XDST;
					end
				end
				ST_XDST:
				begin
					// No pacing beyond the handshakes keeps the byte rate high
					if (dst_gpib)
						link.gpib_wr = 1'b1; // RULE_15 RULE_18
					else
						link.sys_wr = 1'b1; // RULE_15 RULE_17
					st_d = ST_FETCH;
				end
				default: st_d = ST_LOAD;
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
		begin
			st_q   <= ST_LOAD; // RULE_02
			pc_q   <= PTSQ_RST_BYTE;
			op_q   <= PTSQ_RST_BYTE;
			port_q <= PTSQ_RST_BYTE;
			dreg_q <= PTSQ_RST_BYTE;
			loop_q <= PTSQ_RST_BYTE;
			xfer_q <= PTSQ_RST_BYTE;
			flag_q <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			pc_q   <= pc_d;
			op_q   <= op_d;
			port_q <= port_d;
			dreg_q <= dreg_d;
			loop_q <= loop_d;
			xfer_q <= xfer_d;
			flag_q <= flag_d;
		end
	end

	// Program store has no reset; contents are whatever was loaded
	always_ff @(posedge ref_clk_i) begin
		if (mem_we)
			mem[pc_q[AW-1:0]] <= link.io_wdata; // RULE_01 RULE_08
	end

	// Mode and link outputs
	always_comb begin
		case (st_q)
			ST_LOAD: mode_o = PTSQ_MODE_LOAD; // RULE_02
			ST_HALT: mode_o = PTSQ_MODE_HALT;
			default: mode_o = PTSQ_MODE_EXEC;
		endcase
	end

	assign link.busy       = st_q != ST_LOAD && st_q != ST_HALT; // RULE_19
	assign link.dreg       = dreg_q;
	assign link.bus_req    = st_q == ST_XREQ || st_q == ST_XSRC
		|| st_q == ST_XWAIT || st_q == ST_XDST; // RULE_21
	assign link.sys_addr   = port_q; // RULE_10
	assign link.sys_wdata  = xfer_q; // RULE_11
	assign link.gpib_wdata = xfer_q;

endmodule

// ===== logic/ptsq_host.sv
// Host end: CPU port access, bus grant and port / GPIB routing
`timescale 1ns/1ps
module ptsq_host (
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	ptsq_if.host            link,
	input  wire logic       cmd_valid_i,
	input  wire logic       cmd_write_i,
	input  wire logic [7:0] cmd_addr_i,
	input  wire logic [7:0] cmd_wdata_i,
	output logic            cmd_ready_o,
	output logic            rsp_valid_o,
	output logic [7:0]      rsp_data_o,
	input  wire logic [7:0] switches_i,
	output logic [7:0]      port_addr_o,
	output logic            port_rd_o,
	output logic            port_wr_o,
	output logic [7:0]      port_wdata_o,
	input  wire logic [7:0] port_rdata_i,
	input  wire logic       port_hit_i,
	input  wire logic       gpib_rdy_i,
	input  wire logic [7:0] gpib_rdata_i,
	output logic            gpib_rd_o,
	output logic            gpib_wr_o,
	output logic [7:0]      gpib_wdata_o
);
	import ptsq_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE,
		H_RESP,
		H_GAP,
		H_GRANT
	} ptsq_hstate_t;

	// Engine command ports are answered here; reads of them never reach the port bus
	function automatic logic is_local(input logic [7:0] a);
		is_local = a == PTSQ_PORT_SWITCH || a == PTSQ_PORT_EXEC
			|| a == PTSQ_PORT_LOAD;
	endfunction

	ptsq_hstate_t st_q,   st_d;
	logic         ack_q,  ack_d;
	logic         rd_q,   rd_d;
	logic         wr_q,   wr_d;
	logic         isrd_q, isrd_d;
	logic [7:0]   addr_q, addr_d;
	logic [7:0]   wdat_q, wdat_d;
	logic         rv_q,   rv_d;
	logic [7:0]   rsp_q,  rsp_d;
	logic         pend_q, pend_d;
	logic [7:0]   swv;
	logic [7:0]   sw_meta_q;
	logic [7:0]   sw_mid_q;
	logic [7:0]   sw_last_q;
	logic [7:0]   sw_q,   sw_d;

	// Switch pins are asynchronous; take a value only once two stages agree
	always_comb begin
		sw_d = (sw_mid_q == sw_last_q) ? sw_last_q : sw_q;
	end

	// No reset here so the chain fills while reset is still held
	always_ff @(posedge ref_clk_i) begin
		sw_meta_q <= switches_i;
		sw_mid_q  <= sw_meta_q;
		sw_last_q <= sw_mid_q;
		sw_q      <= sw_d;
	end

	assign swv = sw_q & ~(8'h01 << PTSQ_BUSY_BIT);

	// CPU access and bus arbitration
	always_comb begin
		st_d        = st_q;
		ack_d       = ack_q;
		rd_d        = 1'b0;
		wr_d        = 1'b0;
		isrd_d      = isrd_q;
		addr_d      = addr_q;
		wdat_d      = wdat_q;
		rv_d        = 1'b0;
		rsp_d       = rsp_q;
		pend_d      = ack_q && link.sys_rd;
		cmd_ready_o = 1'b0;
		case (st_q)
			H_IDLE:
			begin
				if (link.bus_req)
				begin
					ack_d = 1'b1; // RULE_21
					st_d  = H_GRANT;
				end
				else if (cmd_valid_i)
				begin
					// One command per three cycles keeps load writes apart
					cmd_ready_o = 1'b1;
					rd_d        = !cmd_write_i; // RULE_03 RULE_07
					wr_d        = cmd_write_i;
					isrd_d      = !cmd_write_i;
					addr_d      = cmd_addr_i;
					wdat_d      = cmd_wdata_i;
					st_d        = H_RESP;
				end
			end
			H_RESP:
			begin
				if (isrd_q)
				begin
					rv_d = 1'b1;
					if (addr_q == PTSQ_PORT_SWITCH)
						rsp_d = swv | ({7'h00, link.busy} << PTSQ_BUSY_BIT);
					else if (addr_q == PTSQ_PORT_EXEC)
						rsp_d = link.dreg;
					else if (addr_q == PTSQ_PORT_LOAD)
						rsp_d = 8'h00;
					else
						rsp_d = port_hit_i ? port_rdata_i : 8'hFF;
				end
				st_d = H_GAP;
			end
			H_GAP: st_d = H_IDLE;
			H_GRANT:
			begin
				if (!link.bus_req)
				begin
					ack_d = 1'b0; // RULE_21
					st_d  = H_IDLE;
				end
			end
			default: st_d = H_IDLE;
		endcase
	end

	// Host registers
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
		begin
			st_q   <= H_IDLE;
			ack_q  <= 1'b0;
			rd_q   <= 1'b0;
			wr_q   <= 1'b0;
			isrd_q <= 1'b0;
			addr_q <= 8'h00;
			wdat_q <= 8'h00;
			rv_q   <= 1'b0;
			rsp_q  <= 8'h00;
			pend_q <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			ack_q  <= ack_d;
			rd_q   <= rd_d;
			wr_q   <= wr_d;
			isrd_q <= isrd_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			rv_q   <= rv_d;
			rsp_q  <= rsp_d;
			pend_q <= pend_d;
		end
	end

	// Engine side of the link
	assign link.io_rd    = rd_q;
	assign link.io_wr    = wr_q;
	assign link.io_addr  = addr_q;
	assign link.io_wdata = wdat_q;
	assign link.bus_ack  = ack_q;
	assign rsp_valid_o   = rv_q;
	assign rsp_data_o    = rsp_q;

	// A port that answers overrides the data register left on the bus
	assign link.sys_rvalid = pend_q;
	assign link.sys_rdata  = port_hit_i ? port_rdata_i
		: link.sys_wdata; // RULE_16 RULE_17

	// Port bus belongs to the engine while the grant stands
	assign port_addr_o  = ack_q ? link.sys_addr : addr_q;
	assign port_rd_o    = ack_q ? link.sys_rd
		: (rd_q && !is_local(addr_q));
	assign port_wr_o    = ack_q ? link.sys_wr
		: (wr_q && addr_q != PTSQ_PORT_LOAD);
	assign port_wdata_o = ack_q ? link.sys_wdata : wdat_q;

	// GPIB controller is wired straight through
	assign link.gpib_rdy   = gpib_rdy_i;
	assign link.gpib_rdata = gpib_rdata_i;
	assign gpib_rd_o       = link.gpib_rd;
	assign gpib_wr_o       = link.gpib_wr;
	assign gpib_wdata_o    = link.gpib_wdata;

endmodule

// ===== logic/ptsq_if.sv
// Link between the transfer engine and the host / GPIB side
`timescale 1ns/1ps
interface ptsq_if;
	logic       io_rd;
	logic       io_wr;
	logic [7:0] io_addr;
	logic [7:0] io_wdata;
	logic [7:0] dreg;
	logic       busy;
	logic       bus_req;
	logic       bus_ack;
	logic [7:0] sys_addr;
	logic       sys_rd;
	logic       sys_wr;
	logic [7:0] sys_wdata;
	logic [7:0] sys_rdata;
	logic       sys_rvalid;
	logic       gpib_rdy;
	logic       gpib_rd;
	logic       gpib_wr;
	logic [7:0] gpib_wdata;
	logic [7:0] gpib_rdata;

	modport dev (
		input  io_rd, io_wr, io_addr, io_wdata, bus_ack,
		input  sys_rdata, sys_rvalid, gpib_rdy, gpib_rdata,
		output dreg, busy, bus_req, sys_addr, sys_rd, sys_wr,
		output sys_wdata, gpib_rd, gpib_wr, gpib_wdata
	);

	modport host (
		output io_rd, io_wr, io_addr, io_wdata, bus_ack,
		output sys_rdata, sys_rvalid, gpib_rdy, gpib_rdata,
		input  dreg, busy, bus_req, sys_addr, sys_rd, sys_wr,
		input  sys_wdata, gpib_rd, gpib_wr, gpib_wdata
	);
endinterface

// ===== logic/ptsq_pkg.sv
// Shared constants, encodings and types of the port transfer engine
package ptsq_pkg;

	// I/O ports seen by the host
	localparam logic [7:0] PTSQ_PORT_SWITCH  = 8'hF0;
	localparam logic [7:0] PTSQ_PORT_EXEC    = 8'hF2;
	localparam logic [7:0] PTSQ_PORT_LOAD    = 8'hF3;
	localparam logic [7:0] PTSQ_PORT_PHANTOM = 8'hAF;
	localparam int         PTSQ_BUSY_BIT     = 5;

	// Program store and reset values
	localparam int         PTSQ_PROG_DEPTH = 256;
	localparam logic [7:0] PTSQ_RST_BYTE   = 8'h00;

	// Opcodes, bits 6:5 are ignored by the decoder
	localparam logic [7:0] PTSQ_OP_MASK  = 8'h9F;
	localparam logic [7:0] PTSQ_OP_HALT  = 8'h01;
	localparam logic [7:0] PTSQ_OP_LOOP  = 8'h83;
	localparam logic [7:0] PTSQ_OP_JUMP  = 8'h84;
	localparam logic [7:0] PTSQ_OP_LDATA = 8'h85;
	localparam logic [7:0] PTSQ_OP_LPORT = 8'h86;
	localparam logic [7:0] PTSQ_OP_LLOOP = 8'h87;

	// Transfer group: bit 7 set, bit 2 clear, bits 4:3 destination, 1:0 source
	localparam logic [1:0] PTSQ_DST_NONE = 2'h0;
	localparam logic [1:0] PTSQ_DST_GPIB = 2'h1;
	localparam logic [1:0] PTSQ_SRC_DREG = 2'h0;
	localparam logic [1:0] PTSQ_SRC_PORT = 2'h1;
	localparam logic [1:0] PTSQ_SRC_GPIB = 2'h2;
	localparam logic [1:0] PTSQ_SRC_NONE = 2'h3;

	// Loop counter runs in inverted form and is spent at all ones
	localparam logic [7:0] PTSQ_LOOP_DONE = 8'hFF;

	// Sustained GPIB byte period and its worst-case budget in cycles
	localparam int PTSQ_CLK_NS       = 10;
	localparam int PTSQ_BYTE_NS      = 5000;
	localparam int PTSQ_BYTE_MAX_CYC = PTSQ_BYTE_NS / PTSQ_CLK_NS;

	typedef enum logic [1:0] {
		PTSQ_MODE_LOAD,
		PTSQ_MODE_EXEC,
		PTSQ_MODE_HALT
	} ptsq_mode_t;

	typedef enum logic [2:0] {
		PTSQ_K_NOP,
		PTSQ_K_HALT,
		PTSQ_K_JUMP,
		PTSQ_K_LDATA,
		PTSQ_K_LPORT,
		PTSQ_K_LLOOP,
		PTSQ_K_LOOP,
		PTSQ_K_XFER
	} ptsq_kind_t;

endpackage

// ===== sim/ptsq_asserts.sv
// Concurrent checks on the link between the engine end and the host end
`timescale 1ns/1ps
module ptsq_asserts (
	input wire logic       ref_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       io_rd,
	input wire logic [7:0] io_addr,
	input wire logic       busy,
	input wire logic       bus_req,
	input wire logic       bus_ack,
	input wire logic [7:0] sys_addr,
	input wire logic       sys_rd,
	input wire logic       sys_wr,
	input wire logic       gpib_rd,
	input wire logic       gpib_wr
);
	import ptsq_pkg::*;

	// Byte budget only holds while the GPIB side stays ready
	localparam int BYTE_MAX = PTSQ_BYTE_MAX_CYC;

	logic in_load_q;
	logic in_load_d;

	// Load mode as seen from the command strobes alone
	always_comb
	begin
		in_load_d = in_load_q;
		if (io_rd && io_addr == PTSQ_PORT_LOAD)
			in_load_d = 1'b1;
		else if (io_rd && io_addr == PTSQ_PORT_EXEC)
			in_load_d = 1'b0;
	end

	// Reset lands in load mode
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			in_load_q <= 1'b1;
		else
			in_load_q <= in_load_d;
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	property p_exec_start;
		io_rd && io_addr == PTSQ_PORT_EXEC && in_load_q |=> busy;
	endproperty
	a_exec_start: assert property (p_exec_start)
		else $error("execute read in load mode did not start the engine");

	property p_load_force;
		io_rd && io_addr == PTSQ_PORT_LOAD |=> !busy [*2];
	endproperty
	a_load_force: assert property (p_load_force)
		else $error("load read did not stop the engine");

	property p_halt_hold;
		!busy && !in_load_q |=> !busy;
	endproperty
	a_halt_hold: assert property (p_halt_hold)
		else $error("engine left halt without a load command");

	property p_xfer_grant;
		sys_rd || sys_wr |-> bus_req && bus_ack;
	endproperty
	a_xfer_grant: assert property (p_xfer_grant)
		else $error("port strobe without bus ownership");

	property p_addr_stable;
		bus_req && $past(bus_req) |-> $stable(sys_addr);
	endproperty
	a_addr_stable: assert property (p_addr_stable)
		else $error("port address moved during a transfer");

	property p_one_dst;
		!(sys_wr && gpib_wr);
	endproperty
	a_one_dst: assert property (p_one_dst)
		else $error("two destinations written at once");

	property p_one_src;
		!(sys_rd && gpib_rd);
	endproperty
	a_one_src: assert property (p_one_src)
		else $error("two sources read at once");

	property p_req_bound;
		$rose(bus_req) |-> ##[1:BYTE_MAX] !bus_req;
	endproperty
	a_req_bound: assert property (p_req_bound)
		else $error("transfer overran its byte budget");

	property p_ack_drop;
		$fell(bus_req) |=> !bus_ack;
	endproperty
	a_ack_drop: assert property (p_ack_drop)
		else $error("bus grant kept after request fell");

	c_exec: cover property ($rose(busy));
	c_gpib_wr: cover property (gpib_wr);
	c_port_wr: cover property (sys_wr);
	c_gpib_rd: cover property (gpib_rd);
endmodule

// ===== sim/testbench.sv
// Self-checking bench: host commands drive both ends joined by the link
`timescale 1ns/1ps
module testbench;
	import ptsq_pkg::*;

	logic       ref_clk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       cmd_valid = 1'b0;
	logic       cmd_write = 1'b0;
	logic [7:0] cmd_addr  = 8'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic [7:0] port_addr;
	logic       port_rd;
	logic       port_wr;
	logic [7:0] port_wdata;
	logic       port_hit;
	logic       gpib_rd;
	logic       gpib_wr;
	logic [7:0] gpib_wdata;
	logic [7:0] r;
	logic [7:0] pw[$];
	logic [7:0] gw[$];
	ptsq_mode_t mode;
	int         errors     = 0;
	int         num_checks = 0;
	int         n_grd      = 0;
	int         n_prd      = 0;
	// Data reg, port 40, both transfer groups, loop of three, jump, halt
	logic [7:0] prog [18] = '{8'h85, 8'h3C, 8'h86, 8'h40, 8'h90, 8'h89,
		8'h87, 8'hFC, 8'h92, 8'h83, 8'h08, 8'h84, 8'h0E, 8'h90,
		8'h86, 8'hAF, 8'h88, 8'h01};

	always #5 ref_clk_i = ~ref_clk_i;

	// One live port at 40; every other address, the phantom too, is empty
	assign port_hit = (port_addr == 8'h40);

	ptsq_if link_if ();

	ptsq_device ptsq_device_inst (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.link      (link_if),
		.mode_o    (mode)
	);

	ptsq_host ptsq_host_inst (
		.ref_clk_i    (ref_clk_i),
		.sys_rst_i    (sys_rst_i),
		.link         (link_if),
		.cmd_valid_i  (cmd_valid),
		.cmd_write_i  (cmd_write),
		.cmd_addr_i   (cmd_addr),
		.cmd_wdata_i  (cmd_wdata),
		.cmd_ready_o  (cmd_ready),
		.rsp_valid_o  (rsp_valid),
		.rsp_data_o   (rsp_data),
		.switches_i   (8'h0A),
		.port_addr_o  (port_addr),
		.port_rd_o    (port_rd),
		.port_wr_o    (port_wr),
		.port_wdata_o (port_wdata),
		.port_rdata_i (8'h5A),
		.port_hit_i   (port_hit),
		.gpib_rdy_i   (1'b1),
		.gpib_rdata_i (8'hC3),
		.gpib_rd_o    (gpib_rd),
		.gpib_wr_o    (gpib_wr),
		.gpib_wdata_o (gpib_wdata)
	);

	ptsq_asserts ptsq_asserts_inst (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.io_rd     (link_if.io_rd),
		.io_addr   (link_if.io_addr),
		.busy      (link_if.busy),
		.bus_req   (link_if.bus_req),
		.bus_ack   (link_if.bus_ack),
		.sys_addr  (link_if.sys_addr),
		.sys_rd    (link_if.sys_rd),
		.sys_wr    (link_if.sys_wr),
		.gpib_rd   (link_if.gpib_rd),
		.gpib_wr   (link_if.gpib_wr)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One host port access; a read waits for its response pulse
	task automatic io(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		@(negedge ref_clk_i);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		n = 0;
		#1;
		while (cmd_ready !== 1'b1 && n < 400)
		begin
			@(negedge ref_clk_i);
			#1;
			n++;
		end
		if (n >= 400)
			errors++;
		@(negedge ref_clk_i);
		cmd_valid = 1'b0;
		q = 8'h00;
		n = 0;
		while (!w && rsp_valid !== 1'b1 && n < 8)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		if (!w && n >= 8)
			errors++;
		if (!w)
			q = rsp_data;
		repeat (2) @(negedge ref_clk_i);
	endtask

	// Record what the engine hands out, mid-cycle where strobes have settled
	always @(negedge ref_clk_i)
	begin
		if (port_wr === 1'b1)
		begin
			pw.push_back(port_wdata);
			chk(port_addr, 8'h40);
		end
		if (gpib_wr === 1'b1)
			gw.push_back(gpib_wdata);
		if (gpib_rd === 1'b1)
			n_grd++;
		if (port_rd === 1'b1)
			n_prd++;
	end

	initial
	begin
		#300000;
		errors++;
		results();
	end

	initial
	begin
		repeat (8) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		chk({6'h00, mode}, {6'h00, PTSQ_MODE_LOAD});
		io(1'b0, PTSQ_PORT_SWITCH, 8'h00, r);
		chk(r, 8'h0A);
		io(1'b0, PTSQ_PORT_LOAD, 8'h00, r);
		chk(r, 8'h00);
		foreach (prog[i])
			io(1'b1, PTSQ_PORT_LOAD, prog[i], r);
		// Second pass reruns the stored program without reloading it
		repeat (2)
		begin
			pw.delete();
			gw.delete();
			n_grd = 0;
			n_prd = 0;
			io(1'b0, PTSQ_PORT_EXEC, 8'h00, r);
			chk({6'h00, mode}, {6'h00, PTSQ_MODE_EXEC});
			chk({7'h00, link_if.busy}, 8'h01);
			for (int n = 0; n < 60; n++)
			begin
				io(1'b0, PTSQ_PORT_SWITCH, 8'h00, r);
				if (r[5] === 1'b0)
					break;
			end
			chk(r, 8'h0A);
			chk({6'h00, mode}, {6'h00, PTSQ_MODE_HALT});
			io(1'b0, PTSQ_PORT_EXEC, 8'h00, r);
			chk(r, 8'h3C);
			chk(8'(n_grd), 8'h03);
			chk(8'(n_prd), 8'h02);
			chk({6'h00, mode}, {6'h00, PTSQ_MODE_HALT});
			chk(8'(pw.size()), 8'h04);
			chk(pw[0], 8'h3C);
			chk(pw[3], 8'hC3);
			chk(8'(gw.size()), 8'h02);
			chk(gw[0], 8'h5A);
			chk(gw[1], 8'h3C);
			io(1'b0, PTSQ_PORT_LOAD, 8'h00, r);
			chk({6'h00, mode}, {6'h00, PTSQ_MODE_LOAD});
		end
		results();
	end
endmodule
